// *** hdl/dre_pkg.sv ***
/*
 * Constants shared by the root-entry decode block: entry layout,
 * table geometry and field positions.
 * Assumes a single 50 MHz clock domain and 128-bit entries in memory.
 */
// Operation
// - Clear present bit means entry absent; block every request through it.
// - Present bit set: continue request with the context table it points to; with CHECK_RSV, a set reserved bit faults it instead.
// - Bits 63:12 give the 4KB-aligned context table base for the bus.
// - Pointer bits from host address width up to 63 are treated as zero.
// - Reserved fields and pointer are examined only when present bit set.
package dre_pkg;
    // ------------------------------------------------------------
    // Entry layout
    // ------------------------------------------------------------
    localparam int ENTRY_W = 128;
    localparam int PRESENT_BIT = 0;
    localparam int PTR_LSB = 12;
    localparam int PTR_MSB = 63;
    localparam int RSV_LO_LSB = 1;
    localparam int RSV_LO_MSB = 11;
    localparam int RSV_HI_LSB = 64;
    localparam int RSV_HI_MSB = 127;
    // ------------------------------------------------------------
    // Table geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 64;
    localparam int BUS_W = 8;
    localparam int ENTRY_SHIFT = 4; // Sixteen bytes per entry
    localparam int DEF_HOST_ADDR_WIDTH = 48;
    // ------------------------------------------------------------
    // Outcome of a decode
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        DRE_RES_CONTINUE,
        DRE_RES_BLOCKED,
        DRE_RES_FAULT
    } dre_result_t;
endpackage : dre_pkg

// *** hdl/dre_ptr_mask.sv ***
/*
 * Masks a context-table pointer to the host address width.
 * Assumes the host address width lies between 13 and 64.
 */
`timescale 1ns/10ps
module dre_ptr_mask #(
    parameter int HOST_ADDR_WIDTH = dre_pkg::DEF_HOST_ADDR_WIDTH
) (
    // Raw entry low half
    input wire logic [dre_pkg::ADDR_W-1:0] entry_lo_i,
    // Masked base and flag for nonzero bits above the host width
    output logic [dre_pkg::ADDR_W-1:0] base_o,
    output logic above_width_o
);
    import dre_pkg::*;
    logic [ADDR_W-1:0] keep_mask;
    logic [ADDR_W-1:0] field;

    // Pointer field only, 4KB aligned, then cut at the host width
    always_comb begin
        keep_mask = (HOST_ADDR_WIDTH >= ADDR_W) ? '1 :
            ((ADDR_W'(1) << HOST_ADDR_WIDTH) - ADDR_W'(1));
        field = entry_lo_i & ~((64'(1) << PTR_LSB) - 64'(1));
        base_o = field & keep_mask;
        above_width_o = |(field & ~keep_mask);
    end
endmodule : dre_ptr_mask

// *** hdl/dre_root_decode.sv ***
/*
 * Root-entry decode: forms the entry address from the bus number,
 * issues one memory read, and decides whether the request continues.
 * Assumes memory answers each read exactly once with rd_valid_i,
 * and never while the clock enable is low.
 * Assumes root_base_i is 4KB aligned and held while a fetch is open.
 * Results hold on res_kind_o and ctx_base_o until the next answer.
 */
`timescale 1ns/10ps
module dre_root_decode #(
    parameter int HOST_ADDR_WIDTH = dre_pkg::DEF_HOST_ADDR_WIDTH,
    parameter bit CHECK_RSV = 1'b1
) (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic en_i,
    // Root table base (4KB aligned)
    input wire logic [dre_pkg::ADDR_W-1:0] root_base_i,
    // Request from DMA side
    input wire logic req_valid_i,
    input wire logic [dre_pkg::BUS_W-1:0] req_bus_i,
    output logic req_ready_o,
    // Memory read port
    output logic rd_req_o,
    output logic [dre_pkg::ADDR_W-1:0] rd_addr_o,
    input wire logic rd_valid_i,
    input wire logic [dre_pkg::ENTRY_W-1:0] rd_data_i,
    // Decode result
    output logic res_valid_o,
    output dre_pkg::dre_result_t res_kind_o,
    output logic [dre_pkg::ADDR_W-1:0] ctx_base_o
);
    import dre_pkg::*;

    // Sequencer states
    typedef enum logic [1:0] {S_IDLE, S_READ, S_WAIT, S_DONE} dre_state_t;
    dre_state_t state_q;
    logic [ADDR_W-1:0] addr_q;
    // Captured entry, decode inputs and registered result
    logic [ENTRY_W-1:0] entry_q;
    logic [ADDR_W-1:0] masked_base;
    logic above_width;
    logic present;
    logic rsv_bad;
    logic res_valid_q;
    dre_result_t res_kind_q;
    logic [ADDR_W-1:0] ctx_base_q;

    // Pointer bits that may survive: 63:12, cut at the host width
    localparam logic [ADDR_W-1:0] PTR_KEEP =
        ((ADDR_W'(1) << HOST_ADDR_WIDTH) - ADDR_W'(1)) &
        ~((ADDR_W'(1) << PTR_LSB) - ADDR_W'(1));

    // ------------------------------------------------------------
    // Pointer masking
    // ------------------------------------------------------------
    // Wide pointers are cut silently, never faulted
    dre_ptr_mask #(.HOST_ADDR_WIDTH(HOST_ADDR_WIDTH)) u_mask (
        .entry_lo_i(rd_data_i[PTR_MSB:0]),
        .base_o(masked_base),
        .above_width_o(above_width)
    );

    // Reserved bits checked only as a sanity aid for software
    always_comb begin
        present = rd_data_i[PRESENT_BIT];
        rsv_bad = CHECK_RSV &&
            ((|rd_data_i[RSV_HI_MSB:RSV_HI_LSB]) ||
             (|rd_data_i[RSV_LO_MSB:RSV_LO_LSB]));
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    // One request in flight keeps ordering trivially correct
    // Memory answers outside S_WAIT are not heard
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_q <= S_IDLE;
        end else if (en_i) begin
            unique case (state_q)
                S_IDLE: if (req_valid_i) state_q <= S_READ;
                S_READ: state_q <= S_WAIT;
                S_WAIT: if (rd_valid_i) state_q <= S_DONE;
                S_DONE: state_q <= S_IDLE;
            endcase
        end
    end

    // Entry address: base plus bus times sixteen
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            addr_q <= '0;
        end else if (en_i && state_q == S_IDLE && req_valid_i) begin
            addr_q <= root_base_i +
                (ADDR_W'(req_bus_i) << ENTRY_SHIFT);
        end
    end

    // Capture the entry and decide
    // Reserved bits of an absent entry never reach the decision
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            entry_q <= '0;
            res_kind_q <= DRE_RES_BLOCKED;
            ctx_base_q <= '0;
        end else if (en_i && state_q == S_WAIT && rd_valid_i) begin
            entry_q <= rd_data_i;
            if (!present) begin
                res_kind_q <= DRE_RES_BLOCKED;
                ctx_base_q <= '0; // Pointer ignored when absent
            end else if (rsv_bad) begin
                res_kind_q <= DRE_RES_FAULT;
                ctx_base_q <= '0;
            end else begin
                res_kind_q <= DRE_RES_CONTINUE;
                ctx_base_q <= masked_base;
            end
        end
    end

    // Result strobe, one cycle
    // Frozen with the rest while the enable is low
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            res_valid_q <= 1'b0;
        end else if (en_i) begin
            res_valid_q <= (state_q == S_WAIT) && rd_valid_i;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Handshakes are combinational so a stall drops them at once
    assign req_ready_o = (state_q == S_IDLE) && en_i;
    assign rd_req_o = (state_q == S_READ) && en_i;
    assign rd_addr_o = addr_q;
    assign res_valid_o = res_valid_q;
    assign res_kind_o = res_kind_q;
    assign ctx_base_o = ctx_base_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Outcome of each fetched entry
    absent_blocks_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        en_i && state_q == S_WAIT && rd_valid_i && !present
        |=> res_valid_o && res_kind_o == DRE_RES_BLOCKED)
        else $error("absent entry not blocked");
    present_goes_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        en_i && state_q == S_WAIT && rd_valid_i && present && !rsv_bad
        |=> res_valid_o && res_kind_o == DRE_RES_CONTINUE)
        else $error("present entry not continued");
    blocked_only_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        res_valid_o && res_kind_o == DRE_RES_BLOCKED
        |-> !entry_q[PRESENT_BIT])
        else $error("present entry blocked");
    fault_rsv_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        res_valid_o && res_kind_o == DRE_RES_FAULT
        |-> entry_q[PRESENT_BIT] && CHECK_RSV &&
        ((|entry_q[RSV_HI_MSB:RSV_HI_LSB]) ||
         (|entry_q[RSV_LO_MSB:RSV_LO_LSB])))
        else $error("fault without a present reserved violation");
    absent_ignored_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        res_valid_o && !entry_q[PRESENT_BIT]
        |-> res_kind_o != DRE_RES_FAULT && ctx_base_o == '0)
        else $error("fields of absent entry examined");
    kind_hold_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        !(en_i && state_q == S_WAIT && rd_valid_i)
        |=> $stable(res_kind_o) && $stable(ctx_base_o))
        else $error("result changed without a memory answer");
    res_pulse_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        en_i && res_valid_o |=> !res_valid_o)
        else $error("result strobe held for more than a cycle");

    // Context-table pointer
    base_aligned_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        res_valid_o |-> ctx_base_o[PTR_LSB-1:0] == '0)
        else $error("context base not 4KB aligned");
    ptr_kept_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        res_valid_o && res_kind_o == DRE_RES_CONTINUE
        |-> ((ctx_base_o ^ entry_q[PTR_MSB:0]) & PTR_KEEP) == '0)
        else $error("context base lost pointer bits");
    width_masked_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        res_valid_o |-> (ctx_base_o & ~PTR_KEEP) == '0)
        else $error("pointer bits above host width not cleared");

    // Memory read handshake
    entry_addr_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        en_i && state_q == S_IDLE && req_valid_i ##1 en_i
        |-> rd_req_o && rd_addr_o == $past(root_base_i) +
        (ADDR_W'($past(req_bus_i)) << ENTRY_SHIFT))
        else $error("wrong root entry address");
    rd_once_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        en_i && rd_req_o |=> !rd_req_o)
        else $error("root entry read more than once");
    addr_hold_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        state_q != S_IDLE |=> $stable(rd_addr_o))
        else $error("entry address moved during a fetch");

    // Main scenarios reached
    cov_block_c: cover property (@(posedge clk_i)
        res_valid_o && res_kind_o == DRE_RES_BLOCKED);
    cov_cont_c: cover property (@(posedge clk_i)
        res_valid_o && res_kind_o == DRE_RES_CONTINUE);
    cov_fault_c: cover property (@(posedge clk_i)
        res_valid_o && res_kind_o == DRE_RES_FAULT);
    cov_wide_c: cover property (@(posedge clk_i)
        en_i && state_q == S_WAIT && rd_valid_i && present && above_width);
endmodule : dre_root_decode

// *** tb/dre_mem_model.sv ***
/* Memory holding root entries, keyed by byte address.
   Assumes one read in flight at a time. */
`timescale 1ns/10ps
module dre_mem_model (
    // Clock and read port
    input wire logic clk_i,
    input wire logic rd_req_i,
    input wire logic [63:0] rd_addr_i,
    input wire logic [1:0] dly_i,
    output logic rd_valid_o,
    output logic [127:0] rd_data_o
);
    logic [127:0] mem [logic [63:0]];
    logic [63:0] addr_q;
    logic [1:0] cnt_q;
    logic busy_q = 1'b0;
    initial begin
        rd_valid_o = 1'b0;
        rd_data_o = 128'h0;
    end
    // Variable latency; data toggles so stale values never match
    always @(posedge clk_i) begin
        rd_valid_o <= 1'b0;
        rd_data_o <= ~rd_data_o;
        if (rd_req_i) begin
            addr_q <= rd_addr_i;
            cnt_q <= dly_i;
            busy_q <= 1'b1;
        end else if (busy_q && cnt_q == 2'h0) begin
            rd_valid_o <= 1'b1;
            rd_data_o <= mem[addr_q];
            busy_q <= 1'b0;
        end else if (busy_q) begin
            cnt_q <= cnt_q - 2'h1;
        end
    end
endmodule : dre_mem_model

// *** tb/dre_root_decode_tb.sv ***
/* Random root entries through the decode block.
   Assumes the memory model answers every read. */
`timescale 1ns/10ps
module dre_root_decode_tb;
    import dre_pkg::*;
    localparam int HOST_W_T = 40;
    localparam logic [63:0] MASK = ((64'h1 << HOST_W_T) - 64'h1) & ~64'hfff;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic req_valid_i = 1'b0;
    logic [7:0] req_bus_i = 8'h00;
    logic [63:0] root_base_i = 64'h0;
    logic [1:0] dly = 2'h0;
    logic req_ready_o, rd_req_o, rd_valid_i, res_valid_o;
    logic [63:0] rd_addr_o, ctx_base_o;
    logic [127:0] rd_data_i;
    dre_result_t res_kind_o;
    logic [63:0] seed = 64'h9d90;
    int bad_count = 0;
    int num_checks = 0;
    logic [63:0] q_addr[$];
    logic [63:0] q_ctx[$];
    dre_result_t q_kind[$];
    always #10 clk_i = ~clk_i;
    dre_root_decode #(.HOST_ADDR_WIDTH(HOST_W_T)) dut_u (.clk_i(clk_i),
        .reset_i(reset_i), .en_i(1'b1), .root_base_i(root_base_i),
        .req_valid_i(req_valid_i), .req_bus_i(req_bus_i),
        .req_ready_o(req_ready_o), .rd_req_o(rd_req_o),
        .rd_addr_o(rd_addr_o), .rd_valid_i(rd_valid_i),
        .rd_data_i(rd_data_i), .res_valid_o(res_valid_o),
        .res_kind_o(res_kind_o), .ctx_base_o(ctx_base_o));
    dre_mem_model mem_u (.clk_i(clk_i), .rd_req_i(rd_req_o),
        .rd_addr_i(rd_addr_o), .dly_i(dly), .rd_valid_o(rd_valid_i),
        .rd_data_o(rd_data_i));
    function automatic logic [63:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 7;
        seed ^= seed << 17;
        return seed;
    endfunction : rnd
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wrap_up();
        if (bad_count == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : wrap_up
    // Notes expectations, then holds the request until taken
    task automatic send(input logic [7:0] bus, input logic [127:0] e);
        logic [63:0] a;
        logic rsv;
        int n;
        a = root_base_i + {bus, 4'h0};
        rsv = (e[127:64] != 64'h0) || (e[11:1] != 11'h0);
        mem_u.mem[a] = e;
        q_addr.push_back(a);
        q_kind.push_back(!e[0] ? DRE_RES_BLOCKED :
            rsv ? DRE_RES_FAULT : DRE_RES_CONTINUE);
        q_ctx.push_back(e[0] && !rsv ? e[63:0] & MASK : 64'h0);
        req_valid_i <= 1'b1;
        req_bus_i <= bus;
        n = 0;
        do begin
            @(negedge clk_i);
            n++;
        end while (!req_ready_o && n < 50);
        if (n == 50) bad_count++;
        @(posedge clk_i);
    endtask : send
    // Watcher pairs each result with the oldest note
    always @(negedge clk_i) begin : watch
        dre_result_t ek;
        logic [63:0] ec;
        if (rd_req_o) check(rd_addr_o, q_addr.pop_front());
        if (res_valid_o) begin
            ek = q_kind.pop_front();
            ec = q_ctx.pop_front();
            check(64'(res_kind_o), 64'(ek));
            check(ctx_base_o, ec);
        end
    end
    initial begin : main
        logic [63:0] r;
        logic [63:0] p;
        logic [7:0] b;
        logic [7:0] last;
        logic [127:0] e;
        last = 8'h00;
        repeat (6) @(posedge clk_i);
        reset_i <= 1'b0;
        root_base_i <= rnd() & ~64'hfff;
        @(posedge clk_i);
        for (int i = 0; i < 80; i++) begin
            r = rnd();
            p = rnd();
            e = {64'h0, p[63:12], 11'h000, r[0]};
            if (r[3:2] == 2'h0) e[127:64] = r | 64'h1;
            if (r[3:2] == 2'h1) e[11:1] = r[26:16] | 11'h001;
            b = r[47:40];
            if (b == last) b++;
            last = b;
            dly <= r[5:4];
            send(b, e);
        end
        req_valid_i <= 1'b0;
        repeat (10) @(posedge clk_i);
        check(64'(q_kind.size()), 64'h0);
        check(64'(q_addr.size()), 64'h0);
        wrap_up();
    end
    // Hang guard, far beyond eighty requests
    initial begin
        #(20 * 3000);
        bad_count++;
        wrap_up();
    end
endmodule : dre_root_decode_tb
